//--- verilog/breaker_wear_pkg.sv
// shared constants, types and register map of the breaker wear monitor
package breaker_wear_pkg;
  // ********************
  // widths
  // ********************
  localparam int OPS_W = 18;
  localparam int CUR_W = 14;
  localparam int FRAC_W = 8;
  localparam int LOG_W = 13;
  localparam int REM_W = OPS_W + FRAC_W;
  localparam int NUM_W = 2 * LOG_W;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  // ********************
  // setting limits and values after reset
  // ********************
  localparam logic [OPS_W-1:0] OPS_MAX = 18'h30d40;
  localparam logic [CUR_W-1:0] CUR_MAX = 14'h2710;
  localparam logic [OPS_W-1:0] OPS1_RST = 18'h0c350;
  localparam logic [OPS_W-1:0] OPS2_RST = 18'h00064;
  localparam logic [CUR_W-1:0] CUR1_RST = 14'h0064;
  localparam logic [CUR_W-1:0] CUR2_RST = 14'h07d0;
  localparam logic [OPS_W-1:0] ALM1_RST = 18'h003e8;
  localparam logic [OPS_W-1:0] ALM2_RST = 18'h00064;
  // ********************
  // register offsets
  // ********************
  localparam logic [ADDR_W-1:0] REG_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] REG_OPS1 = 6'h04;
  localparam logic [ADDR_W-1:0] REG_OPS2 = 6'h08;
  localparam logic [ADDR_W-1:0] REG_CUR1 = 6'h0c;
  localparam logic [ADDR_W-1:0] REG_CUR2 = 6'h10;
  localparam logic [ADDR_W-1:0] REG_ALM1 = 6'h14;
  localparam logic [ADDR_W-1:0] REG_ALM2 = 6'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS = 6'h1c;
  localparam logic [ADDR_W-1:0] REG_REM1 = 6'h20;
  localparam logic [ADDR_W-1:0] REG_REM2 = 6'h24;
  localparam logic [ADDR_W-1:0] REG_REM3 = 6'h28;
  localparam logic [ADDR_W-1:0] REG_COUNT = 6'h2c;
  localparam logic [ADDR_W-1:0] REG_CMD = 6'h30;
  // ********************
  // field positions
  // ********************
  localparam int CTRL_W = 7;
  localparam int CTRL_ALM1_EN = 0;
  localparam int CTRL_ALM2_EN = 1;
  localparam int CTRL_TRIG_LSB = 2;
  localparam int CTRL_FORCE_LSB = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam int CMD_RELOAD = 0;
  localparam int CMD_CLR_COUNT = 1;
  // ********************
  // types
  // ********************
  typedef enum logic [1:0] {
    FORCE_NORMAL = 2'h0,
    FORCE_ALARM1 = 2'h1,
    FORCE_ALARM2 = 2'h2
  } forceStatus_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PREP = 4'h2,
    ST_DIV = 4'h4,
    ST_APPLY = 4'h8
  } wearState_e;
  typedef struct packed {
    logic [2:0][CUR_W-1:0] mag;
  } phaseCurrents_s;
endpackage

//--- verilog/log2_approx.sv
// piecewise linear base two logarithm, integer part and fraction
`timescale 1ns/1ps
module log2_approx #(
  parameter int IN_W = 18,
  parameter int FRAC_W = 8,
  parameter int OUT_W = 13
) (
  input wire logic [IN_W-1:0] value,
  output logic [OUT_W-1:0] logValue
);
  if (OUT_W != FRAC_W + 5 || IN_W > 32 || IN_W <= FRAC_W) begin : g_bad
    $error("log2_approx: unsupported widths");
  end
  logic [4:0] pos;
  logic [IN_W-1:0] norm;
  // zero input reads as log of one; callers never divide by it
  always_comb begin
    pos = 5'h00;
    for (int i = 0; i < IN_W; i++) begin
      if (value[i]) begin
        pos = 5'(i);
      end
    end
    norm = value << (5'(IN_W - 1) - pos);
    logValue = {pos, norm[IN_W-2 -: FRAC_W]};
  end
endmodule // log2_approx

//--- verilog/serial_div.sv
// restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module serial_div #(
  parameter int NUM_W = 26,
  parameter int DEN_W = 13
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic start,
  input wire logic [NUM_W-1:0] numerator,
  input wire logic [DEN_W-1:0] denominator,
  output logic done,
  output logic [NUM_W-1:0] quotient
);
  if (NUM_W > 62 || DEN_W < 2) begin : g_bad
    $error("serial_div: unsupported widths");
  end
  logic [DEN_W:0] rem_ff, nxt_rem;
  logic [NUM_W-1:0] quo_ff, nxt_quo;
  logic [5:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;
  logic [DEN_W:0] trial;
  always_comb begin
    nxt_rem = rem_ff;
    nxt_quo = quo_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    trial = {rem_ff[DEN_W-1:0], quo_ff[NUM_W-1]};
    if (start) begin
      nxt_rem = '0;
      nxt_quo = numerator;
      nxt_cnt = 6'(NUM_W);
    end else if (cnt_ff != 6'h00) begin
      nxt_cnt = cnt_ff - 6'h01;
      nxt_done = (cnt_ff == 6'h01);
      if (trial >= {1'b0, denominator}) begin
        nxt_rem = trial - {1'b0, denominator};
        nxt_quo = {quo_ff[NUM_W-2:0], 1'b1};
      end else begin
        nxt_rem = trial;
        nxt_quo = {quo_ff[NUM_W-2:0], 1'b0};
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rem_ff <= '0;
      quo_ff <= '0;
      cnt_ff <= 6'h00;
      done_ff <= 1'b0;
    end else begin
      rem_ff <= nxt_rem;
      quo_ff <= nxt_quo;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end
  assign done = done_ff;
  assign quotient = quo_ff;
endmodule // serial_div

//--- verilog/breaker_wear_monitor.sv
// breaker wear monitor: trip capture, wear arithmetic, alarms and registers
//
// Overview of operation
// - a rising edge of the chosen breaker open output captures all three phase currents.
// - each captured opening subtracts per phase the wear it used from that phase's remaining operations.
// - two independent alarm stages assert when a phase's remaining operations fall below their limit.
// - a control field selects which output acts as the breaker open trigger.
// - the captured inputs are the fundamental magnitudes of the three phase currents.
// - a force field (normal, alarm 1, alarm 2) overrides the status while global forcing is on; here the normal value leaves the alarms unforced.
// - the settings are static and no setting group affects them.
// - operations 1 takes 0 to 200000, default 50000, the count at nominal current.
// - operations 2 takes 0 to 200000, default 100, the count at breaking current.
// - current 1 takes 0 to 100.00 kA in 0.01 kA steps, default 1 kA.
// - current 2 takes the same range and step, default 20 kA.
// - the wear curve is set only by the two current and count points.
// - each stage has an enable, off by default, and a limit of 0 to 200000 (1000 and 100 by default).
// - the remaining operations of each phase are readable separately.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
module breaker_wear_monitor #(
  parameter int NUM_OUTS = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [NUM_OUTS-1:0] tripOutputs,
  input wire breaker_wear_pkg::phaseCurrents_s phaseCurrents,
  input wire logic forceEnable,
  input wire logic [breaker_wear_pkg::ADDR_W-1:0] regAddr,
  input wire logic [breaker_wear_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [breaker_wear_pkg::DATA_W-1:0] regRdata,
  output logic alarm1,
  output logic alarm2
);
  if (NUM_OUTS < 1 || NUM_OUTS > 8) begin : g_bad
    $error("breaker_wear_monitor: NUM_OUTS must be 1 to 8");
  end
  localparam int OW = breaker_wear_pkg::OPS_W;
  localparam int CW = breaker_wear_pkg::CUR_W;
  localparam int LW = breaker_wear_pkg::LOG_W;
  localparam int RW = breaker_wear_pkg::REM_W;
  localparam int FW = breaker_wear_pkg::FRAC_W;

  // ********************
  // settings and commands
  // ********************
  logic [breaker_wear_pkg::CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [OW-1:0] ops1_ff, nxt_ops1, ops2_ff, nxt_ops2, alm1Set_ff, nxt_alm1Set, alm2Set_ff, nxt_alm2Set;
  logic [CW-1:0] cur1_ff, nxt_cur1, cur2_ff, nxt_cur2;
  logic wrOps, wrCur, reload, clrCount;
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ops1 = ops1_ff;
    nxt_ops2 = ops2_ff;
    nxt_alm1Set = alm1Set_ff;
    nxt_alm2Set = alm2Set_ff;
    nxt_cur1 = cur1_ff;
    nxt_cur2 = cur2_ff;
    // out of range values are dropped, the old setting stays
    wrOps = regWr && regWdata <= 32'(breaker_wear_pkg::OPS_MAX);
    wrCur = regWr && regWdata <= 32'(breaker_wear_pkg::CUR_MAX);
    reload = regWr && regAddr == breaker_wear_pkg::REG_CMD && regWdata[breaker_wear_pkg::CMD_RELOAD];
    clrCount = regWr && regAddr == breaker_wear_pkg::REG_CMD && regWdata[breaker_wear_pkg::CMD_CLR_COUNT];
    if (regWr && regAddr == breaker_wear_pkg::REG_CTRL) begin
      nxt_ctrl = regWdata[breaker_wear_pkg::CTRL_W-1:0];
    end
    if (wrOps && regAddr == breaker_wear_pkg::REG_OPS1) nxt_ops1 = regWdata[OW-1:0];
    if (wrOps && regAddr == breaker_wear_pkg::REG_OPS2) nxt_ops2 = regWdata[OW-1:0];
    if (wrOps && regAddr == breaker_wear_pkg::REG_ALM1) nxt_alm1Set = regWdata[OW-1:0];
    if (wrOps && regAddr == breaker_wear_pkg::REG_ALM2) nxt_alm2Set = regWdata[OW-1:0];
    if (wrCur && regAddr == breaker_wear_pkg::REG_CUR1) nxt_cur1 = regWdata[CW-1:0];
    if (wrCur && regAddr == breaker_wear_pkg::REG_CUR2) nxt_cur2 = regWdata[CW-1:0];
  end
  // single copy of each setting, no group input exists
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_ff <= breaker_wear_pkg::CTRL_RST;
      ops1_ff <= breaker_wear_pkg::OPS1_RST;
      ops2_ff <= breaker_wear_pkg::OPS2_RST;
      cur1_ff <= breaker_wear_pkg::CUR1_RST;
      cur2_ff <= breaker_wear_pkg::CUR2_RST;
      alm1Set_ff <= breaker_wear_pkg::ALM1_RST;
      alm2Set_ff <= breaker_wear_pkg::ALM2_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      ops1_ff <= nxt_ops1;
      ops2_ff <= nxt_ops2;
      cur1_ff <= nxt_cur1;
      cur2_ff <= nxt_cur2;
      alm1Set_ff <= nxt_alm1Set;
      alm2Set_ff <= nxt_alm2Set;
    end
  end

  // ********************
  // logarithms of the two curve points and the phase under work
  // ********************
  logic [4:0][OW-1:0] logIn;
  logic [4:0][LW-1:0] logs;
  breaker_wear_pkg::phaseCurrents_s capt_ff, nxt_capt, work_ff, nxt_work;
  logic [1:0] phase_ff, nxt_phase;
  assign logIn[0] = OW'(work_ff.mag[phase_ff]);
  assign logIn[1] = OW'(cur1_ff);
  assign logIn[2] = OW'(cur2_ff);
  assign logIn[3] = ops1_ff;
  assign logIn[4] = ops2_ff;
  for (genvar g = 0; g < 5; g++) begin : g_log
    log2_approx #(.IN_W(OW), .FRAC_W(FW), .OUT_W(LW)) u_log (
      .value(logIn[g]),
      .logValue(logs[g])
    );
  end

  // ********************
  // wear engine
  // ********************
  breaker_wear_pkg::wearState_e state_ff, nxt_state;
  logic [2:0][RW-1:0] rem_ff, nxt_rem;
  logic [31:0] opCount_ff, nxt_opCount;
  logic trigPrev_ff, pending_ff, nxt_pending, divStart_ff, nxt_divStart;
  logic [LW-1:0] expo_ff, nxt_expo, den_ff, nxt_den, span, dI, dN;
  logic [2*LW-1:0] num_ff, nxt_num, quotient;
  logic [RW-1:0] consumed, remCur;
  logic trigSel, trigEdge, divDone;
  serial_div #(.NUM_W(2 * LW), .DEN_W(LW)) u_div (
    .clock(clock),
    .rstn(rstn),
    .start(divStart_ff),
    .numerator(num_ff),
    .denominator(den_ff),
    .done(divDone),
    .quotient(quotient)
  );
  always_comb begin
    trigSel = tripOutputs[ctrl_ff[breaker_wear_pkg::CTRL_TRIG_LSB +: 3]];
    trigEdge = trigSel && !trigPrev_ff;
    // log-log line through both points; below point one a trip costs one operation
    span = (logs[2] > logs[1]) ? logs[2] - logs[1] : '0;
    dN = (logs[3] > logs[4]) ? logs[3] - logs[4] : '0;
    dI = (logs[0] <= logs[1]) ? '0 : (logs[0] >= logs[2]) ? span : logs[0] - logs[1];
    consumed = RW'({1'b1, expo_ff[FW-1:0]}) << expo_ff[LW-1:FW];
    remCur = rem_ff[phase_ff];
    nxt_state = state_ff;
    nxt_rem = rem_ff;
    nxt_capt = capt_ff;
    nxt_work = work_ff;
    nxt_phase = phase_ff;
    nxt_expo = expo_ff;
    nxt_num = num_ff;
    nxt_den = den_ff;
    nxt_divStart = 1'b0;
    nxt_opCount = clrCount ? 32'h0 : opCount_ff;
    // a trigger in the clear cycle still counts, set wins
    nxt_pending = trigEdge || (pending_ff && state_ff != breaker_wear_pkg::ST_IDLE);
    if (trigEdge) begin
      nxt_capt = phaseCurrents;
      nxt_opCount = nxt_opCount + 32'h1;
    end
    case (state_ff)
      breaker_wear_pkg::ST_IDLE: begin
        if (pending_ff) begin
          nxt_work = capt_ff;
          nxt_phase = 2'h0;
          nxt_state = breaker_wear_pkg::ST_PREP;
        end
      end
      breaker_wear_pkg::ST_PREP: begin
        if (span == '0 || dN == '0 || dI == '0) begin
          nxt_expo = '0;
          nxt_state = breaker_wear_pkg::ST_APPLY;
        end else begin
          nxt_num = dI * dN;
          nxt_den = span;
          nxt_divStart = 1'b1;
          nxt_state = breaker_wear_pkg::ST_DIV;
        end
      end
      breaker_wear_pkg::ST_DIV: begin
        if (divDone) begin
          nxt_expo = quotient[LW-1:0];
          nxt_state = breaker_wear_pkg::ST_APPLY;
        end
      end
      breaker_wear_pkg::ST_APPLY: begin
        nxt_rem[phase_ff] = (remCur > consumed) ? remCur - consumed : '0;
        nxt_phase = phase_ff + 2'h1;
        nxt_state = (phase_ff == 2'h2) ? breaker_wear_pkg::ST_IDLE : breaker_wear_pkg::ST_PREP;
      end
      default: nxt_state = breaker_wear_pkg::ST_IDLE;
    endcase
    if (reload) begin
      nxt_rem = {3{ops1_ff, FW'(0)}};
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_ff <= breaker_wear_pkg::ST_IDLE;
      rem_ff <= {3{breaker_wear_pkg::OPS1_RST, 8'h00}};
      capt_ff <= '0;
      work_ff <= '0;
      phase_ff <= 2'h0;
      expo_ff <= '0;
      num_ff <= '0;
      den_ff <= '0;
      divStart_ff <= 1'b0;
      opCount_ff <= 32'h0;
      trigPrev_ff <= 1'b0;
      pending_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rem_ff <= nxt_rem;
      capt_ff <= nxt_capt;
      work_ff <= nxt_work;
      phase_ff <= nxt_phase;
      expo_ff <= nxt_expo;
      num_ff <= nxt_num;
      den_ff <= nxt_den;
      divStart_ff <= nxt_divStart;
      opCount_ff <= nxt_opCount;
      trigPrev_ff <= trigSel;
      pending_ff <= nxt_pending;
    end
  end

  // ********************
  // alarms, forcing and read port
  // ********************
  logic alarm1_ff, nxt_alarm1, alarm2_ff, nxt_alarm2, forceOn;
  logic [breaker_wear_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [1:0] forceSel, condition;
  logic below1, below2;
  always_comb begin
    below1 = 1'b0;
    below2 = 1'b0;
    for (int p = 0; p < 3; p++) begin
      below1 = below1 || rem_ff[p][RW-1:FW] < alm1Set_ff;
      below2 = below2 || rem_ff[p][RW-1:FW] < alm2Set_ff;
    end
    forceSel = ctrl_ff[breaker_wear_pkg::CTRL_FORCE_LSB +: 2];
    forceOn = forceEnable && forceSel != breaker_wear_pkg::FORCE_NORMAL;
    nxt_alarm1 = forceOn ? forceSel == breaker_wear_pkg::FORCE_ALARM1 :
                 below1 && ctrl_ff[breaker_wear_pkg::CTRL_ALM1_EN];
    nxt_alarm2 = forceOn ? forceSel == breaker_wear_pkg::FORCE_ALARM2 :
                 below2 && ctrl_ff[breaker_wear_pkg::CTRL_ALM2_EN];
    condition = alarm2_ff ? 2'h2 : alarm1_ff ? 2'h1 : 2'h0;
    nxt_rdata = '0;
    if (regRd) begin
      case (regAddr)
        breaker_wear_pkg::REG_CTRL: nxt_rdata = 32'(ctrl_ff);
        breaker_wear_pkg::REG_OPS1: nxt_rdata = 32'(ops1_ff);
        breaker_wear_pkg::REG_OPS2: nxt_rdata = 32'(ops2_ff);
        breaker_wear_pkg::REG_CUR1: nxt_rdata = 32'(cur1_ff);
        breaker_wear_pkg::REG_CUR2: nxt_rdata = 32'(cur2_ff);
        breaker_wear_pkg::REG_ALM1: nxt_rdata = 32'(alm1Set_ff);
        breaker_wear_pkg::REG_ALM2: nxt_rdata = 32'(alm2Set_ff);
        breaker_wear_pkg::REG_STATUS: nxt_rdata = 32'({pending_ff || state_ff != breaker_wear_pkg::ST_IDLE,
                                                       condition, alarm2_ff, alarm1_ff});
        breaker_wear_pkg::REG_REM1: nxt_rdata = 32'(rem_ff[0][RW-1:FW]);
        breaker_wear_pkg::REG_REM2: nxt_rdata = 32'(rem_ff[1][RW-1:FW]);
        breaker_wear_pkg::REG_REM3: nxt_rdata = 32'(rem_ff[2][RW-1:FW]);
        breaker_wear_pkg::REG_COUNT: nxt_rdata = opCount_ff;
        default: nxt_rdata = '0;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      alarm1_ff <= 1'b0;
      alarm2_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      alarm1_ff <= nxt_alarm1;
      alarm2_ff <= nxt_alarm2;
      rdata_ff <= nxt_rdata;
    end
  end
  assign alarm1 = alarm1_ff;
  assign alarm2 = alarm2_ff;
  assign regRdata = rdata_ff;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  chk_capture_on_trip: assert property (trigEdge |=> capt_ff == $past(phaseCurrents))
    else $error("currents not captured on trip edge");
  chk_trigger_select: assert property (!trigSel ##1 trigSel |=> pending_ff)
    else $error("selected trip output did not start capture");
  chk_wear_drops: assert property (state_ff == breaker_wear_pkg::ST_APPLY && remCur != '0 && !reload
    |=> rem_ff[$past(phase_ff)] < $past(remCur))
    else $error("remaining operations did not fall");
  chk_min_wear: assert property (state_ff == breaker_wear_pkg::ST_APPLY |-> consumed >= RW'(256))
    else $error("wear per opening below one operation");
  chk_job_bounded: assert property ($rose(pending_ff) && state_ff == breaker_wear_pkg::ST_IDLE
    |-> ##[1:120] state_ff == breaker_wear_pkg::ST_IDLE && !pending_ff)
    else $error("wear job did not finish");
  chk_alarm_level: assert property (!forceOn && ctrl_ff[0] && below1 |=> alarm1)
    else $error("alarm 1 missing");
  chk_alarm_disabled: assert property (!forceOn && !ctrl_ff[1] |=> !alarm2)
    else $error("disabled alarm 2 active");
  chk_force_status: assert property (forceEnable && forceSel == breaker_wear_pkg::FORCE_ALARM1
    |=> alarm1 && !alarm2)
    else $error("forced status ignored");
  chk_ops_range: assert property (regWr && regAddr == breaker_wear_pkg::REG_OPS1
    && regWdata > 32'(breaker_wear_pkg::OPS_MAX) |=> $stable(ops1_ff))
    else $error("out of range operations accepted");
  chk_cur_range: assert property (regWr && regAddr == breaker_wear_pkg::REG_CUR2
    && regWdata > 32'(breaker_wear_pkg::CUR_MAX) |=> $stable(cur2_ff))
    else $error("out of range current accepted");
  chk_rem_read: assert property (regRd && regAddr == breaker_wear_pkg::REG_REM2
    |=> regRdata == 32'($past(rem_ff[1][RW-1:FW])))
    else $error("remaining read wrong");
endmodule // breaker_wear_monitor

//--- verif/breaker_model.sv
// breaker and current measurement model driving the monitor's trip and current inputs
`timescale 1ns/1ps
module breaker_model (
  input wire logic clock,
  input wire logic fire,
  input wire logic [2:0] fireIdx,
  input wire logic [2:0][breaker_wear_pkg::CUR_W-1:0] cur,
  output logic [7:0] tripOutputs,
  output breaker_wear_pkg::phaseCurrents_s phaseCurrents
);
  // ********************
  // open command contact and measurement
  // ********************
  // the trip outputs settle at the first edge, while reset is still held; the currents stay unknown until the first fire
  int hold = 0;
  logic [2:0] idx = 3'h0;
  // currents settle two cycles before the contact closes, so the capture edge sees them
  always @(posedge clock) begin
    if (fire) begin
      phaseCurrents.mag <= cur;
      idx <= fireIdx;
      hold <= 5;
    end else if (hold > 0) begin
      hold <= hold - 1;
      tripOutputs <= (hold <= 4) ? (8'h01 << idx) : 8'h00;
    end else begin
      tripOutputs <= 8'h00;
    end
  end
endmodule // breaker_model

//--- verif/tb.sv
// self-checking bench of the breaker wear monitor
`timescale 1ns/1ps
module tb;
  // ********************
  // signals
  // ********************
  logic clock, rstn, forceEnable, regWr, regRd, fire, alarm1, alarm2;
  logic [5:0] regAddr;
  logic [31:0] regWdata, regRdata, rd;
  logic [7:0] tripOutputs;
  logic [2:0] fireIdx, ti;
  logic [2:0][breaker_wear_pkg::CUR_W-1:0] cur;
  breaker_wear_pkg::phaseCurrents_s phaseCurrents;
  int n_fail, num_checks, seed, cnt, mn, o2;
  real rem[3];
  int act[3];
  logic [5:0] ta[12] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h20, 6'h24, 6'h28, 6'h2c, 6'h34};
  logic [31:0] tv[12] = '{0, 50000, 100, 100, 2000, 1000, 100, 50000, 50000, 50000, 0, 0};
  logic [5:0] wa[9] = '{6'h04, 6'h04, 6'h04, 6'h08, 6'h0c, 6'h0c, 6'h0c, 6'h10, 6'h20};
  logic [31:0] wd[9] = '{200001, 200000, 50000, 200001, 10001, 10000, 100, 10001, 5};
  logic [31:0] we[9] = '{50000, 200000, 50000, 100, 100, 10000, 100, 2000, 50000};
  breaker_wear_monitor #(.NUM_OUTS(8)) DUT (.clock(clock), .rstn(rstn), .tripOutputs(tripOutputs),
    .phaseCurrents(phaseCurrents), .forceEnable(forceEnable), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .alarm1(alarm1), .alarm2(alarm2));
  breaker_model model (.clock(clock), .fire(fire), .fireIdx(fireIdx), .cur(cur), .tripOutputs(tripOutputs),
    .phaseCurrents(phaseCurrents));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ********************
  // tasks
  // ********************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdr(input logic [5:0] a);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    rd = regRdata;
  endtask
  // ideal wear per opening on the log-log line through both points
  function automatic real used(input int c);
    real x;
    if (c <= 100) return 1.0;
    if (c >= 2000) return 50000.0 / o2;
    x = $ln(c / 100.0) / $ln(20.0);
    return $pow(50000.0 / o2, x);
  endfunction
  task automatic trip(input logic [2:0] idx, input int a, input int b, input int c);
    int k;
    @(posedge clock);
    fire <= 1'b1;
    fireIdx <= idx;
    cur <= {c[13:0], b[13:0], a[13:0]};
    @(posedge clock);
    fire <= 1'b0;
    repeat (8) @(posedge clock);
    k = 0;
    rdr(6'h1c);
    while (rd[4] !== 1'b0 && k < 100) begin
      rdr(6'h1c);
      k++;
    end
    if (k == 100) begin
      n_fail++;
      results();
    end
  endtask
  task automatic tripChk(input logic [2:0] idx, input int a, input int b, input int c);
    int cs[3];
    int e, tol;
    cs = '{a, b, c};
    trip(idx ^ 3'h1, a, b, c);
    rdr(6'h2c);
    chk("count unselected", rd, cnt);
    trip(idx, a, b, c);
    cnt++;
    rdr(6'h2c);
    chk("count", rd, cnt);
    for (int p = 0; p < 3; p++) begin
      rem[p] = rem[p] - used(cs[p]);
      // log and antilog are piecewise linear, so wear sits a few percent off the ideal curve
      e = $rtoi(rem[p]);
      tol = $rtoi(0.08 * (50000.0 - rem[p])) + 2;
      rdr(6'h20 + 6'(4 * p));
      act[p] = rd;
      chk("remaining", (rd + tol >= e && rd <= e + tol) ? e : rd, e);
    end
  endtask
  task automatic alm(input logic a1, input logic a2);
    repeat (3) @(posedge clock);
    #1;
    chk("alarm1", alarm1, a1);
    chk("alarm2", alarm2, a2);
  endtask
  // ********************
  // main sequence
  // ********************
  initial begin
    seed = 32'ha7d62fbc;
    rstn = 1'b0;
    {forceEnable, regWr, regRd, fire} = 4'h0;
    regAddr = '0;
    regWdata = '0;
    fireIdx = '0;
    cur = '0;
    {n_fail, num_checks, cnt} = '0;
    rem = '{50000, 50000, 50000};
    o2 = 100;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    foreach (ta[i]) begin
      rdr(ta[i]);
      chk("default", rd, tv[i]);
    end
    // out of range and read-only writes keep the old value
    foreach (wa[i]) begin
      wr(wa[i], wd[i]);
      rdr(wa[i]);
      chk("setting", rd, we[i]);
    end
    tripChk(3'h0, 50, 2000, 3000);
    repeat (3) begin
      ti = 3'($random(seed));
      wr(6'h00, {27'h0, ti, 2'h0});
      tripChk(ti, $random(seed) & 63, 2000 + ($random(seed) & 2047), $random(seed) & 127);
    end
    mn = act[0];
    foreach (act[p]) mn = (act[p] < mn) ? act[p] : mn;
    wr(6'h14, mn + 1);
    wr(6'h18, mn);
    wr(6'h00, 32'h3);
    alm(1'b1, 1'b0);
    rdr(6'h1c);
    chk("status", rd[3:0], 4'h5);
    wr(6'h18, mn + 1);
    alm(1'b1, 1'b1);
    wr(6'h00, 32'h0);
    alm(1'b0, 1'b0);
    wr(6'h00, 32'h40);
    alm(1'b0, 1'b0);
    @(posedge clock);
    forceEnable <= 1'b1;
    for (int f = 0; f < 3; f++) begin
      wr(6'h00, 32'(f << 5));
      alm(f == 1, f == 2);
    end
    @(posedge clock);
    forceEnable <= 1'b0;
    // second point moved: the curve follows the settings alone
    o2 = 1000;
    wr(6'h08, o2);
    wr(6'h30, 32'h3);
    rem = '{50000, 50000, 50000};
    cnt = 0;
    tripChk(3'h0, $random(seed) & 63, 1000, 2000 + ($random(seed) & 4095));
    rdr(6'h24);
    chk("interpolated", 32'(rd <= 49995 && rd >= 49955), 32'h1);
    results();
  end
endmodule // tb
